//--- logic/vlc_pkg.sv
// Shared constants of the link error and configuration block.
// Assumes a 25 MHz system clock used as the crystal clock.
package vlc_pkg;
   // Register offsets on the local register port
   localparam logic [1:0] ADDR_DELAY_CFG = 2'h0;
   localparam logic [1:0] ADDR_CTRL_ONE = 2'h1;
   localparam logic [1:0] ADDR_STATE_VEC = 2'h2;
   // Fields of transceiver_delay_config
   localparam int DCFG_XCVR_SEL_BIT = 7;
   localparam int DCFG_RX_POL_BIT = 6;
   localparam int DCFG_OFFSET_LSB = 0;
   localparam logic [3:0] DCFG_OFFSET_RST = 4'h7;
   localparam logic DCFG_RX_POL_RST = 1'b1;
   localparam logic DCFG_XCVR_SEL_RST = 1'b0;
   // Fields of link_control_one
   localparam int CTL_IGNORE_BIT = 7;
   localparam int CTL_CLKSEL_BIT = 6;
   localparam int CTL_RATE_LSB = 4;
   localparam int CTL_IE_BIT = 1;
   localparam logic [1:0] CTL_RATE_RST = 2'h0;
   // State vector codes
   localparam logic [7:0] SV_NONE = 8'h00;
   localparam logic [7:0] SV_LOST_ARB = 8'h14;
   localparam logic [7:0] SV_CRC_ERR = 8'h18;
   localparam logic [7:0] SV_INVALID = 8'h1c;
   // Symbol codes from the symbol decoder
   localparam logic [2:0] SYM_ZERO = 3'h0;
   localparam logic [2:0] SYM_ONE = 3'h1;
   localparam logic [2:0] SYM_SOF = 3'h2;
   localparam logic [2:0] SYM_EOD = 3'h3;
   localparam logic [2:0] SYM_EOF = 3'h4;
   localparam logic [2:0] SYM_BREAK = 3'h5;
   localparam logic [2:0] SYM_INVALID = 3'h6;
   // Delay compensation, in microseconds of link time
   localparam int DELAY_BASE_US = 9;
   // Longest active pulse ever driven, kept below any break length
   localparam int MAX_ACTIVE_US = 239;
   // Passive time that counts as an idle bus
   localparam int IDLE_US = 300;
   localparam logic [8:0] IDLE_TICKS = 9'(IDLE_US);
   localparam logic [7:0] MAX_ACTIVE_TICKS = 8'(MAX_ACTIVE_US);
endpackage : vlc_pkg

//--- logic/vlc_link_err.sv
// Error handling and configuration registers of a VPW serial link controller.
// Assumes a symbol decoder and protocol handler on the same clock feed the
// symbol and transmit inputs; the receive pin is asynchronous.
//
// Overview of operation
// - Invalid symbol seen while transmitting reports lost arbitration, not transmit error.
// - Symbol error sets invalid flag, shown after lost arbitration in state vector.
// - End-of-data or end-of-frame off a byte boundary sets invalid flag.
// - Active symbol received while sending end-of-data sets invalid flag.
// - No transmission starts while the bus is held active.
// - Drive that never shows active reports invalid, aborts, waits new command.
// - After a temporary fault, reception and transmission resume unaided.
// - Break received outside hunt state or while sending raises invalid flag; state vector read clears it.
// - After break, wait for idle bus, then start-of-frame.
// - Block never drives a break; active drive length is capped.
// - CRC mismatch raises CRC flag, then bus ignored until start-of-frame.
// - Invalid bits during own transmission stop it at once, raise invalid.
// - Four-bit delay offset selects 9 to 24 us in 1 us steps.
// - Delay offset resets to code 0111, sixteen microseconds.
// - Delay configuration takes only the first write after reset; always readable.
// - Receive polarity one passes the pin, zero inverts it.
// - Ignore bit disables receiver, masks requests, holds status at reset.
// - Ignore bit clears itself on received start-of-frame or break.
// - Clock select one means 1.048576 MHz link clock, zero 1 MHz.
// - Rate select divides crystal clock by 1, 2, 4, 8; written once.
// - Interrupt enable gates run-mode requests; requests persist until source cleared.
// - Interrupt enable one permits, zero blocks requests.
`timescale 1ns/10ps
`default_nettype none
module vlc_link_err
   import vlc_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic [1:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   input wire logic RX_PIN_IN,
   output logic TX_PIN_OUT,
   input wire logic SYM_VALID_IN,
   input wire logic [2:0] SYM_CODE_IN,
   input wire logic SYM_ACTIVE_IN,
   input wire logic BYTE_BOUNDARY_IN,
   input wire logic CRC_ERR_IN,
   input wire logic TX_CMD_IN,
   input wire logic TX_DRIVE_IN,
   input wire logic TX_EOD_IN,
   input wire logic TX_DONE_IN,
   output logic TX_GRANT_OUT,
   output logic RX_ENABLE_OUT,
   output logic BUS_ACTIVE_OUT,
   output logic LINK_TICK_OUT,
   output logic LINK_CLK_SEL_OUT,
   output logic [7:0] DELAY_TICKS_OUT,
   output logic IRQ_OUT
);

   typedef enum {RX_HUNT, RX_FRAME, RX_WAIT_IDLE} vlc_rx_t;
   typedef enum {TX_IDLE, TX_PEND, TX_RUN} vlc_tx_t;

   // Highest pending state vector code, lost arbitration first
   function automatic logic [7:0] sv_code(input logic lost_arbitration, input logic inv, input logic crc);
   begin
      sv_code = lost_arbitration ? SV_LOST_ARB : (inv ? SV_INVALID : (crc ? SV_CRC_ERR : SV_NONE));
   end
   endfunction : sv_code

   logic rx_meta_q;
   logic rx_sync_q;
   logic bus_active;
   logic [3:0] offset_q;
   logic rx_pol_q;
   logic xcvr_sel_q;
   logic dcfg_locked_q;
   logic ignore_q;
   logic clk_sel_q;
   logic [1:0] rate_q;
   logic rate_locked_q;
   logic ie_q;
   logic [2:0] div_cnt_q;
   logic [2:0] div_mask;
   logic tick;
   logic [7:0] delay_us;
   logic [7:0] delay_ticks;
   vlc_rx_t rx_q;
   vlc_tx_t tx_q;
   logic [8:0] idle_cnt_q;
   logic bus_idle;
   logic [7:0] nodrive_cnt_q;
   logic [7:0] act_cnt_q;
   logic loa_q, inv_q, crc_q;
   logic set_loa, set_inv, set_crc;
   logic sv_read;
   logic [7:0] sv_now;
   logic sym_sof, sym_brk, sym_invalid;
   logic frame_err;
   logic eod_clash;
   logic ground_fault;
   logic tx_abort;
   logic [7:0] rdata_q;

   // Receive pin synchroniser
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         rx_meta_q <= 1'b0;
         rx_sync_q <= 1'b0;
      end
      else
      begin
         rx_meta_q <= RX_PIN_IN;
         rx_sync_q <= rx_meta_q;
      end
   end

   assign bus_active = rx_pol_q ? rx_sync_q : ~rx_sync_q;
   assign BUS_ACTIVE_OUT = bus_active;

   // Write-once delay and transceiver configuration
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         offset_q <= DCFG_OFFSET_RST;
         rx_pol_q <= DCFG_RX_POL_RST;
         xcvr_sel_q <= DCFG_XCVR_SEL_RST;
         dcfg_locked_q <= 1'b0;
      end
      else if (WR_IN && ADDR_IN == ADDR_DELAY_CFG && !dcfg_locked_q)
      begin
         offset_q <= WDATA_IN[DCFG_OFFSET_LSB +: 4];
         rx_pol_q <= WDATA_IN[DCFG_RX_POL_BIT];
         xcvr_sel_q <= WDATA_IN[DCFG_XCVR_SEL_BIT];
         dcfg_locked_q <= 1'b1;
      end
   end

   // Control register one; rate select write-once
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         clk_sel_q <= 1'b0;
         ie_q <= 1'b0;
         rate_q <= CTL_RATE_RST;
         rate_locked_q <= 1'b0;
      end
      else if (WR_IN && ADDR_IN == ADDR_CTRL_ONE)
      begin
         clk_sel_q <= WDATA_IN[CTL_CLKSEL_BIT];
         ie_q <= WDATA_IN[CTL_IE_BIT];
         if (!rate_locked_q)
         begin
            rate_q <= WDATA_IN[CTL_RATE_LSB +: 2];
            rate_locked_q <= 1'b1;
         end
      end
   end

   // Ignore bit; the self-clear wins over a same-cycle write
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         ignore_q <= 1'b0;
      else if (sym_sof || sym_brk)
         ignore_q <= 1'b0;
      else if (WR_IN && ADDR_IN == ADDR_CTRL_ONE)
         ignore_q <= WDATA_IN[CTL_IGNORE_BIT];
   end

   // Link clock as a tick from the divided crystal clock
   assign div_mask = (rate_q == 2'h0) ? 3'h0 : (rate_q == 2'h1) ? 3'h1 :
                     (rate_q == 2'h2) ? 3'h3 : 3'h7;
   assign tick = (div_cnt_q & div_mask) == div_mask;
   assign LINK_TICK_OUT = tick;
   assign LINK_CLK_SEL_OUT = clk_sel_q;

   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         div_cnt_q <= 3'h0;
      else
         div_cnt_q <= div_cnt_q + 3'h1;
   end

   // Delay compensation in link ticks, scaled for a binary link clock
   assign delay_us = 8'(DELAY_BASE_US) + {4'h0, offset_q};
   assign delay_ticks = clk_sel_q ? delay_us + {4'h0, delay_us[7:4]} : delay_us;
   assign DELAY_TICKS_OUT = delay_ticks;

   // Symbol qualification
   assign sym_sof = SYM_VALID_IN && SYM_CODE_IN == SYM_SOF;
   assign sym_brk = SYM_VALID_IN && SYM_CODE_IN == SYM_BREAK;
   assign sym_invalid = SYM_VALID_IN && SYM_CODE_IN == SYM_INVALID;
   assign frame_err = SYM_VALID_IN && !BYTE_BOUNDARY_IN && rx_q == RX_FRAME &&
                      (SYM_CODE_IN == SYM_EOD || SYM_CODE_IN == SYM_EOF);
   assign eod_clash = SYM_VALID_IN && SYM_ACTIVE_IN && TX_EOD_IN && tx_q == TX_RUN;
   assign ground_fault = tx_q == TX_RUN && nodrive_cnt_q > delay_ticks;
   assign tx_abort = tx_q == TX_RUN &&
                     (sym_invalid || frame_err || eod_clash || ground_fault || sym_brk ||
                      act_cnt_q >= MAX_ACTIVE_TICKS);

   // Idle detector: passive bus for the idle time
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         idle_cnt_q <= 9'h0;
      else if (bus_active)
         idle_cnt_q <= 9'h0;
      else if (tick && idle_cnt_q != IDLE_TICKS)
         idle_cnt_q <= idle_cnt_q + 9'h1;
   end

   assign bus_idle = idle_cnt_q == IDLE_TICKS;

   // Receive framing state
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         rx_q <= RX_HUNT;
      else
      begin
         case (rx_q)
            RX_HUNT:
               if (sym_brk)
                  rx_q <= RX_WAIT_IDLE;
               else if (sym_sof)
                  rx_q <= RX_FRAME;
            RX_FRAME:
               if (sym_brk)
                  rx_q <= RX_WAIT_IDLE;
               else if (CRC_ERR_IN || frame_err || ignore_q)
                  rx_q <= RX_HUNT;
               else if (SYM_VALID_IN && SYM_CODE_IN == SYM_EOF)
                  rx_q <= RX_HUNT;
            RX_WAIT_IDLE:
               if (bus_idle)
                  rx_q <= RX_HUNT;
            default:
               rx_q <= RX_HUNT;
         endcase
      end
   end

   assign RX_ENABLE_OUT = rx_q == RX_FRAME && !ignore_q;

   // Transmit permission state
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         tx_q <= TX_IDLE;
      else
      begin
         case (tx_q)
            TX_IDLE:
               if (TX_CMD_IN)
                  tx_q <= TX_PEND;
            TX_PEND:
               if (!bus_active && rx_q != RX_WAIT_IDLE)
                  tx_q <= TX_RUN;
            TX_RUN:
               if (tx_abort || TX_DONE_IN)
                  tx_q <= TX_IDLE;
            default:
               tx_q <= TX_IDLE;
         endcase
      end
   end

   assign TX_GRANT_OUT = tx_q == TX_RUN && !tx_abort;
   assign TX_PIN_OUT = TX_GRANT_OUT && TX_DRIVE_IN;

   // Drive without echo, and active-length cap
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         nodrive_cnt_q <= 8'h0;
         act_cnt_q <= 8'h0;
      end
      else
      begin
         if (tx_q != TX_RUN || !TX_DRIVE_IN || bus_active)
            nodrive_cnt_q <= 8'h0;
         else if (tick && nodrive_cnt_q != 8'hff)
            nodrive_cnt_q <= nodrive_cnt_q + 8'h1;
         if (!TX_PIN_OUT)
            act_cnt_q <= 8'h0;
         else if (tick && act_cnt_q != 8'hff)
            act_cnt_q <= act_cnt_q + 8'h1;
      end
   end

   // State vector flags; a set beats a read clear
   assign set_loa = sym_invalid && tx_q == TX_RUN;
   assign set_inv = sym_invalid || frame_err || eod_clash || ground_fault ||
                    (sym_brk && rx_q != RX_HUNT) || (sym_brk && tx_q == TX_RUN);
   assign set_crc = CRC_ERR_IN && rx_q == RX_FRAME;
   assign sv_now = sv_code(loa_q, inv_q, crc_q);
   assign sv_read = RD_IN && ADDR_IN == ADDR_STATE_VEC;

   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
      begin
         loa_q <= 1'b0;
         inv_q <= 1'b0;
         crc_q <= 1'b0;
      end
      else if (ignore_q && !(sym_sof || sym_brk))
      begin
         loa_q <= 1'b0;
         inv_q <= 1'b0;
         crc_q <= 1'b0;
      end
      else
      begin
         loa_q <= set_loa || (loa_q && !(sv_read && sv_now == SV_LOST_ARB));
         inv_q <= set_inv || (inv_q && !(sv_read && sv_now == SV_INVALID));
         crc_q <= set_crc || (crc_q && !(sv_read && sv_now == SV_CRC_ERR));
      end
   end

   assign IRQ_OUT = (loa_q || inv_q || crc_q) && ie_q && !ignore_q;

   // Read data, one cycle after the strobe
   always_ff @(posedge CLK_IN or negedge RESETN_IN)
   begin
      if (!RESETN_IN)
         rdata_q <= 8'h00;
      else if (RD_IN)
      begin
         case (ADDR_IN)
            ADDR_DELAY_CFG:
               rdata_q <= {xcvr_sel_q, rx_pol_q, 2'h0, offset_q};
            ADDR_CTRL_ONE:
               rdata_q <= {ignore_q, clk_sel_q, rate_q, 2'h0, ie_q, 1'b0};
            ADDR_STATE_VEC:
               rdata_q <= sv_now;
            default:
               rdata_q <= 8'h00;
         endcase
      end
      else
         rdata_q <= 8'h00;
   end

   assign RDATA_OUT = rdata_q;

   a_loa_on_tx_inv: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (sym_invalid && tx_q == TX_RUN && !ignore_q) |=> loa_q && inv_q)
      else $error("invalid symbol while sending did not flag lost arbitration");
   a_sv_loa_first: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (sv_read && loa_q && inv_q) |=> RDATA_OUT == SV_LOST_ARB)
      else $error("lost arbitration not shown ahead of invalid symbol");
   a_frame_err_flag: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (frame_err && !ignore_q) |=> inv_q)
      else $error("off-boundary end symbol did not set invalid flag");
   a_no_start_active: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (tx_q == TX_PEND && bus_active) |=> tx_q != TX_RUN)
      else $error("transmission started on an active bus");
   a_ground_abort: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      ground_fault |-> !TX_PIN_OUT ##1 tx_q == TX_IDLE)
      else $error("undriven bus did not abort the frame");
   a_break_wait_idle: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (sym_brk && rx_q == RX_FRAME) |=> rx_q == RX_WAIT_IDLE)
      else $error("break did not force a wait for idle");
   a_drive_capped: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      act_cnt_q <= MAX_ACTIVE_TICKS)
      else $error("active drive ran into break length");
   a_delay_code: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      !clk_sel_q |-> delay_ticks == 8'(DELAY_BASE_US) + {4'h0, offset_q})
      else $error("delay compensation not linear in offset");
   a_cfg_write_once: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (dcfg_locked_q && WR_IN && ADDR_IN == ADDR_DELAY_CFG) |=> $stable(offset_q))
      else $error("delay configuration changed after first write");
   a_ignore_clears: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (sym_sof || sym_brk) |=> !ignore_q)
      else $error("ignore bit not cleared by start or break");
   a_irq_gating: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      (!ie_q || ignore_q) |-> !IRQ_OUT)
      else $error("interrupt request not masked");

   c_tx_done: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      tx_q == TX_RUN ##1 tx_q == TX_IDLE);
   c_crc_err: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) set_crc);
   c_break_rx: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
      rx_q == RX_WAIT_IDLE ##1 rx_q == RX_HUNT);
   c_ground_fault: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN) ground_fault);

endmodule : vlc_link_err
`default_nettype wire

//--- tb/vlc_bus_model.sv
// Far-side model: the shared bus with other nodes, seen through a transceiver.
// Assumes the bench sets node and fault controls by NBA at a rising edge.
`timescale 1ns/10ps
`default_nettype none
module vlc_bus_model
(
   input wire logic drive_in,
   input wire logic other_in,
   input wire logic short_bat_in,
   input wire logic short_gnd_in,
   input wire logic invert_in,
   output logic rx_pin_out
);
   logic bus_level;
   // Wired bus; a ground short beats every driver
   assign bus_level = (drive_in | other_in | short_bat_in) & ~short_gnd_in;
   // Some transceivers invert the receive path
   assign rx_pin_out = bus_level ^ invert_in;
endmodule : vlc_bus_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the link error and configuration block.
// Assumes the bus model stands for the transceiver and the far bus.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import vlc_pkg::*;
();
   logic clk, rstn, wr, rd, sym_v, sym_a, bnd, crc, cmd, drv, eod, done;
   logic other, sbat, sgnd, inv, tx_pin, rx_pin, grant, rx_en, bus_act, tick, csel, irq;
   logic [1:0] addr;
   logic [2:0] sym_c;
   logic [7:0] wdata, rdata, dticks, d;
   logic [2:0] fr_code [3] = '{SYM_EOD, SYM_EOF, SYM_EOD};
   logic [7:0] fr_exp [3] = '{SV_INVALID, SV_INVALID, SV_NONE};
   int err_total, n_checks, n;

   vlc_link_err vlc_link_err_i
   (
      .CLK_IN(clk), .RESETN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
      .RD_IN(rd), .RDATA_OUT(rdata), .RX_PIN_IN(rx_pin), .TX_PIN_OUT(tx_pin),
      .SYM_VALID_IN(sym_v), .SYM_CODE_IN(sym_c), .SYM_ACTIVE_IN(sym_a),
      .BYTE_BOUNDARY_IN(bnd), .CRC_ERR_IN(crc), .TX_CMD_IN(cmd), .TX_DRIVE_IN(drv),
      .TX_EOD_IN(eod), .TX_DONE_IN(done), .TX_GRANT_OUT(grant), .RX_ENABLE_OUT(rx_en),
      .BUS_ACTIVE_OUT(bus_act), .LINK_TICK_OUT(tick), .LINK_CLK_SEL_OUT(csel),
      .DELAY_TICKS_OUT(dticks), .IRQ_OUT(irq)
   );

   vlc_bus_model vlc_bus_model_i
   (
      .drive_in(tx_pin), .other_in(other), .short_bat_in(sbat), .short_gnd_in(sgnd),
      .invert_in(inv), .rx_pin_out(rx_pin)
   );

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic chk1(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1

   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : step

   task automatic do_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      step(1);
   endtask : do_reset

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   task automatic sym(input logic [2:0] c, input logic act);
      @(posedge clk);
      sym_c <= c;
      sym_a <= act;
      sym_v <= 1'b1;
      @(posedge clk);
      sym_v <= 1'b0;
      step(2);
   endtask : sym

   // 0 CRC mismatch, 1 transmit command, 2 frame done
   task automatic pulse(input int w);
      @(posedge clk);
      crc <= (w == 0);
      cmd <= (w == 1);
      done <= (w == 2);
      @(posedge clk);
      {crc, cmd, done} <= 3'h0;
      step(2);
   endtask : pulse

   task automatic cnt_ticks();
      n = 0;
      repeat (64)
      begin
         @(posedge clk);
         #1 n += int'(tick);
      end
   endtask : cnt_ticks

   task automatic wait_grant(input logic v, input int lim);
      while (grant !== v)
      begin
         if (lim == 0)
         begin
            err_total++;
            $display("BAD grant expected %b seen %b", v, grant);
            give_verdict();
         end
         lim--;
         step(1);
      end
   endtask : wait_grant

   initial
   begin
      {rstn, wr, rd, sym_v, sym_a, bnd, crc, cmd, drv, eod, done} = '0;
      {other, sbat, sgnd, inv} = '0;
      addr = '0;
      wdata = '0;
      sym_c = '0;
      err_total = 0;
      n_checks = 0;
      do_reset();
      rd_reg(ADDR_DELAY_CFG, d);
      chk("dcfg reset", 8'h47, d & 8'hcf);
      chk("delay reset", 8'd16, dticks);
      rd_reg(2'h3, d);
      chk("unmapped", 8'h00, d);
      @(posedge clk) other <= 1'b1;
      step(4);
      chk1("bus true pol", 1'b1, bus_act);
      @(posedge clk) other <= 1'b0;
      @(posedge clk) inv <= 1'b1;
      for (int k = 0; k < 16; k++)
      begin
         do_reset();
         wr_reg(ADDR_DELAY_CFG, 8'(k));
         wr_reg(ADDR_DELAY_CFG, 8'h48);
         chk("delay code", 8'(9 + k), dticks);
         wr_reg(ADDR_CTRL_ONE, {2'h0, 2'(k), 4'h2});
         cnt_ticks();
         chk("ticks", 8'(64 >> (k % 4)), 8'(n));
      end
      rd_reg(ADDR_DELAY_CFG, d);
      chk("dcfg locked", 8'h0f, d & 8'hcf);
      @(posedge clk) other <= 1'b1;
      step(4);
      chk1("bus inv pol", 1'b1, bus_act);
      @(posedge clk) other <= 1'b0;
      wr_reg(ADDR_CTRL_ONE, 8'h42);
      chk("delay binary", 8'd25, dticks);
      chk1("clk sel", 1'b1, csel);
      cnt_ticks();
      chk("rate locked", 8'd8, 8'(n));
      wr_reg(ADDR_CTRL_ONE, 8'h02);
      chk("delay integer", 8'd24, dticks);
      rd_reg(ADDR_CTRL_ONE, d);
      chk("ctl read", 8'h32, d & 8'hf2);
      for (int i = 0; i < 3; i++)
      begin
         sym(SYM_SOF, 1'b1);
         @(posedge clk) bnd <= (i == 2);
         sym(fr_code[i], 1'b0);
         chk1("irq flag", i != 2, irq);
         rd_reg(ADDR_STATE_VEC, d);
         chk("framing", fr_exp[i], d);
         chk1("irq cleared", 1'b0, irq);
      end
      sym(SYM_SOF, 1'b1);
      pulse(0);
      chk1("crc irq", 1'b1, irq);
      chk1("crc rx off", 1'b0, rx_en);
      rd_reg(ADDR_STATE_VEC, d);
      chk("crc code", SV_CRC_ERR, d);
      sym(SYM_SOF, 1'b1);
      @(posedge clk) other <= 1'b1;
      step(4);
      sym(SYM_BREAK, 1'b1);
      @(posedge clk) other <= 1'b0;
      chk1("break irq", 1'b1, irq);
      rd_reg(ADDR_STATE_VEC, d);
      chk("break code", SV_INVALID, d);
      chk1("break cleared", 1'b0, irq);
      sym(SYM_SOF, 1'b1);
      chk1("sof before idle", 1'b0, rx_en);
      step(2600);
      sym(SYM_SOF, 1'b1);
      chk1("sof after idle", 1'b1, rx_en);
      pulse(1);
      wait_grant(1'b1, 10);
      @(posedge clk) drv <= 1'b1;
      step(1);
      chk1("tx pin", 1'b1, tx_pin);
      sym(SYM_INVALID, 1'b1);
      chk1("tx stopped", 1'b0, grant);
      chk1("pin released", 1'b0, tx_pin);
      @(posedge clk) drv <= 1'b0;
      rd_reg(ADDR_STATE_VEC, d);
      chk("lost arb", SV_LOST_ARB, d);
      rd_reg(ADDR_STATE_VEC, d);
      chk("invalid queued", SV_INVALID, d);
      rd_reg(ADDR_STATE_VEC, d);
      chk("sv empty", SV_NONE, d);
      pulse(1);
      wait_grant(1'b1, 10);
      @(posedge clk) eod <= 1'b1;
      sym(SYM_ZERO, 1'b1);
      rd_reg(ADDR_STATE_VEC, d);
      chk("eod collision", SV_INVALID, d);
      @(posedge clk) eod <= 1'b0;
      pulse(2);
      wait_grant(1'b0, 10);
      @(posedge clk) sbat <= 1'b1;
      step(4);
      pulse(1);
      step(50);
      chk1("held off", 1'b0, grant);
      @(posedge clk) sbat <= 1'b0;
      wait_grant(1'b1, 40);
      pulse(2);
      wait_grant(1'b0, 10);
      @(posedge clk) sgnd <= 1'b1;
      pulse(1);
      wait_grant(1'b1, 10);
      @(posedge clk) drv <= 1'b1;
      wait_grant(1'b0, 400);
      rd_reg(ADDR_STATE_VEC, d);
      chk("ground fault", SV_INVALID, d);
      @(posedge clk) drv <= 1'b0;
      @(posedge clk) sgnd <= 1'b0;
      step(20);
      chk1("stays idle", 1'b0, grant);
      pulse(1);
      wait_grant(1'b1, 10);
      pulse(2);
      pulse(0);
      sym(SYM_SOF, 1'b1);
      wr_reg(ADDR_CTRL_ONE, 8'h82);
      chk1("ignore rx off", 1'b0, rx_en);
      pulse(0);
      chk1("ignore masked", 1'b0, irq);
      rd_reg(ADDR_STATE_VEC, d);
      chk("ignore status", SV_NONE, d);
      sym(SYM_SOF, 1'b1);
      rd_reg(ADDR_CTRL_ONE, d);
      chk("ignore cleared", 8'h00, d & 8'h80);
      pulse(0);
      chk1("irq resumed", 1'b1, irq);
      wr_reg(ADDR_CTRL_ONE, 8'h00);
      chk1("ie off", 1'b0, irq);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
